// [core/ofr_defines.vh]
`ifndef OFR_DEFINES_VH
`define OFR_DEFINES_VH
// register indexes (printed offsets are not multiples of four)
`define OFR_IDX_PINSEL    8'h93
`define OFR_IDX_OPTION    8'h94
`define OFR_IDX_FLAGS     8'h95
`define OFR_IDX_WAKE      8'h96
`define OFR_IDX_IRQEN     8'h97
`define OFR_IDX_EVCLR     8'h98
`define OFR_IDX_EVSTAT    8'h99
// field positions, pin_function_select
`define OFR_PS_ROUTE      7
`define OFR_PS_T2OE       6
`define OFR_PS_T1OE       5
`define OFR_PS_T0OE       4
// field positions, peripheral_option
`define OFR_OP_ONEWIRE    7
`define OFR_OP_T3CLK      6
// flag bit positions
`define OFR_FL_ADC        4
`define OFR_FL_EXT2       2
`define OFR_FL_PCHG       1
`define OFR_FL_T3         0
// reset values
`define OFR_RST_PINSEL    8'h05
`define OFR_RST_ZERO      8'h00
// implemented flag bits and event status bits
`define OFR_FLAG_MASK     8'h17
`define OFR_EV_MASK       8'h0f
// timer0 output divider terminal count; the pin toggles every 32 overflows
`define OFR_T0_HALF       6'h1f
// field ranges
`define OFR_PS_P21        3:2
`define OFR_PS_P20        1:0
`define OFR_OP_WDT        5:4
`define OFR_OP_ADCK       3:2
`define OFR_OP_T3IV       1:0
// pin mode reset code
`define OFR_RST_PMODE     2'h1
// timer3 interval per code, in timer3 clocks
`define OFR_T3IV_00       17'h08000
`define OFR_T3IV_01       17'h04000
`define OFR_T3IV_10       17'h02000
`define OFR_T3IV_11       17'h10000
// watchdog period per code, in ms
`define OFR_WDT_00        9'h190
`define OFR_WDT_01        9'h0c8
`define OFR_WDT_10        9'h064
`define OFR_WDT_11        9'h032
// converter clock divisor per code
`define OFR_ADCK_00       6'h20
`define OFR_ADCK_01       6'h10
`define OFR_ADCK_10       6'h08
`define OFR_ADCK_11       6'h04
`endif

// [core/ofr_option_regs.v]
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ofr_defines.vh"
module ofr_option_regs (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // engine events, same clock
  input  wire        adcDone,
  input  wire        adcStart,
  input  wire        timer3Tick,
  input  wire        timer0Ovf,
  input  wire        timer1Ovf,
  input  wire        timer2Ovf,
  input  wire        ext2Ack,
  input  wire        pinChgAck,
  input  wire        timer3Ack,
  // pins, asynchronous
  input  wire        ext2Pin,
  input  wire [7:0]  port1Pins,
  // decoded settings
  output reg         uartTxOnP31,
  output reg         uartTxOnP16,
  output reg         uartSinglePin,
  output reg  [1:0]  pin21Mode,
  output reg  [1:0]  pin20Mode,
  output reg         timer3FastClk,
  output reg  [16:0] timer3Interval,
  output reg  [8:0]  watchdogPeriodMs,
  output reg  [5:0]  adcClkDiv,
  output reg  [7:0]  port1WakeBits,
  // pin drives
  output reg         p10Drive,
  output reg         p10Oe,
  output reg         p35Drive,
  output reg         p35Oe,
  output reg         p34Drive,
  output reg         p34Oe,
  // flags and interrupt
  output reg         conversionDoneFlag,
  output reg         extIrq2EdgeFlag,
  output reg         pinChangeFlag,
  output reg         thirdTimerFlag,
  output reg         irqOut
);

  // ==========================================================
  // state
  reg [7:0]  pinSel_r;
  reg [7:0]  option_r;
  reg [7:0]  wake_r;
  reg [3:0]  irqEn_r;
  reg [3:0]  evStat_r;
  reg [4:0]  flags_r;
  reg [1:0]  ext2Sync_r;
  reg        ext2Prev_r;
  reg [7:0]  p1Sync0_r;
  reg [7:0]  p1Sync1_r;
  reg [7:0]  p1Prev_r;
  reg        t2Tog_r;
  reg        t1Tog_r;
  reg        t0Tog_r;
  reg [5:0]  t0Cnt_r;
  reg [4:0]  flags_nxt;
  reg [3:0]  evStat_nxt;
  reg [31:0] rdata_nxt;
  reg        err_nxt;

  wire [9:0] widx = paddr[11:2];
  wire       acc = psel & penable & ~pready;
  wire       wr = acc & pwrite;
  wire       wrFlags = wr & (widx == {2'h0, `OFR_IDX_FLAGS});
  wire       wrClr = wr & (widx == {2'h0, `OFR_IDX_EVCLR});

  // valid register index check, used for read and write
  function hit;
    input [9:0] idx;
    begin
      hit = (idx >= {2'h0, `OFR_IDX_PINSEL}) && (idx <= {2'h0, `OFR_IDX_EVSTAT});
    end
  endfunction

  // ==========================================================
  // pin synchronisers and edge detection
  wire ext2Fall = ext2Prev_r & ~ext2Sync_r[1];
  wire [7:0] p1Change = (p1Sync1_r ^ p1Prev_r) & wake_r;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ext2Sync_r <= 2'h3;
      ext2Prev_r <= 1'b1;
      p1Sync0_r  <= `OFR_RST_ZERO;
      p1Sync1_r  <= `OFR_RST_ZERO;
      p1Prev_r   <= `OFR_RST_ZERO;
    end else begin
      ext2Sync_r <= {ext2Sync_r[0], ext2Pin};
      ext2Prev_r <= ext2Sync_r[1];
      p1Sync0_r  <= port1Pins;
      p1Sync1_r  <= p1Sync0_r;
      p1Prev_r   <= p1Sync1_r;
    end
  end

  // ==========================================================
  // flag next state; set wins over any clear
  wire [3:0] evSet = {|p1Change, ext2Fall, adcDone, timer3Tick};
  always @* begin
    flags_nxt = flags_r;
    if (wrFlags) begin
      flags_nxt[4] = flags_r[4] & pwdata[`OFR_FL_ADC];
      flags_nxt[2] = flags_r[2] & pwdata[`OFR_FL_EXT2];
      flags_nxt[1] = flags_r[1] & pwdata[`OFR_FL_PCHG];
      flags_nxt[0] = flags_r[0] & pwdata[`OFR_FL_T3];
    end
    if (adcStart) begin
      flags_nxt[4] = 1'b0;
    end
    if (ext2Ack) begin
      flags_nxt[2] = 1'b0;
    end
    if (pinChgAck) begin
      flags_nxt[1] = 1'b0;
    end
    if (timer3Ack) begin
      flags_nxt[0] = 1'b0;
    end
    flags_nxt[3] = 1'b0;
    if (adcDone) begin
      flags_nxt[4] = 1'b1;
    end
    if (ext2Fall) begin
      flags_nxt[2] = 1'b1;
    end
    if (|p1Change) begin
      flags_nxt[1] = 1'b1;
    end
    if (timer3Tick) begin
      flags_nxt[0] = 1'b1;
    end
  end

  // sticky event status: w1 clear, set wins
  always @* begin
    evStat_nxt = evStat_r;
    if (wrClr) begin
      evStat_nxt = evStat_r & ~pwdata[3:0];
    end
    evStat_nxt = evStat_nxt | evSet;
  end

  // ==========================================================
  // apb read mux and error
  always @* begin
    rdata_nxt = 32'h0;
    err_nxt = ~hit(widx);
    case (widx)
      {2'h0, `OFR_IDX_PINSEL}: rdata_nxt[7:0] = pinSel_r;
      {2'h0, `OFR_IDX_OPTION}: rdata_nxt[7:0] = option_r;
      {2'h0, `OFR_IDX_FLAGS}:  rdata_nxt[4:0] = flags_r;
      {2'h0, `OFR_IDX_WAKE}:   rdata_nxt[7:0] = wake_r;
      {2'h0, `OFR_IDX_IRQEN}:  rdata_nxt[3:0] = irqEn_r;
      {2'h0, `OFR_IDX_EVSTAT}: rdata_nxt[3:0] = evStat_r;
      default:                 rdata_nxt = 32'h0;
    endcase
  end

  // ==========================================================
  // registers and apb handshake, one wait state
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pinSel_r <= `OFR_RST_PINSEL;
      option_r <= `OFR_RST_ZERO;
      wake_r   <= `OFR_RST_ZERO;
      irqEn_r  <= 4'h0;
      evStat_r <= 4'h0;
      flags_r  <= 5'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
    end else begin
      pready   <= acc;
      pslverr  <= acc & err_nxt;
      prdata   <= (acc & ~pwrite) ? rdata_nxt : 32'h0;
      flags_r  <= flags_nxt;
      evStat_r <= evStat_nxt;
      if (wr && widx == {2'h0, `OFR_IDX_PINSEL}) begin
        pinSel_r <= pwdata[7:0];
      end
      if (wr && widx == {2'h0, `OFR_IDX_OPTION}) begin
        option_r <= pwdata[7:0];
      end
      if (wr && widx == {2'h0, `OFR_IDX_WAKE}) begin
        wake_r <= pwdata[7:0];
      end
      if (wr && widx == {2'h0, `OFR_IDX_IRQEN}) begin
        irqEn_r <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // timer overflow dividers; overflow pulses from engines
  always @(posedge sys_clk) begin
    if (!nrst) begin
      t2Tog_r <= 1'b0;
      t1Tog_r <= 1'b0;
      t0Tog_r <= 1'b0;
      t0Cnt_r <= 6'h0;
    end else begin
      if (timer2Ovf) begin
        t2Tog_r <= ~t2Tog_r;
      end
      if (timer1Ovf) begin
        t1Tog_r <= ~t1Tog_r;
      end
      if (timer0Ovf) begin
        if (t0Cnt_r == `OFR_T0_HALF) begin
          t0Cnt_r <= 6'h0;
          t0Tog_r <= ~t0Tog_r;
        end else begin
          t0Cnt_r <= t0Cnt_r + 6'h1;
        end
      end
    end
  end

  // ==========================================================
  // decoded outputs, all registered
  always @(posedge sys_clk) begin
    if (!nrst) begin
      uartTxOnP31 <= 1'b1;
      uartTxOnP16 <= 1'b0;
      uartSinglePin <= 1'b0;
      pin21Mode <= `OFR_RST_PMODE;
      pin20Mode <= `OFR_RST_PMODE;
      timer3FastClk <= 1'b0;
      timer3Interval <= `OFR_T3IV_00;
      watchdogPeriodMs <= `OFR_WDT_00;
      adcClkDiv <= `OFR_ADCK_00;
      port1WakeBits <= 8'h0;
      p10Drive <= 1'b0;
      p10Oe <= 1'b0;
      p35Drive <= 1'b0;
      p35Oe <= 1'b0;
      p34Drive <= 1'b0;
      p34Oe <= 1'b0;
      conversionDoneFlag <= 1'b0;
      extIrq2EdgeFlag <= 1'b0;
      pinChangeFlag <= 1'b0;
      thirdTimerFlag <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      uartTxOnP31 <= ~pinSel_r[`OFR_PS_ROUTE];
      uartTxOnP16 <= pinSel_r[`OFR_PS_ROUTE];
      uartSinglePin <= option_r[`OFR_OP_ONEWIRE];
      // pin mode fields, 11 passed as is
      pin21Mode <= pinSel_r[`OFR_PS_P21];
      pin20Mode <= pinSel_r[`OFR_PS_P20];
      timer3FastClk <= option_r[`OFR_OP_T3CLK];
      case (option_r[`OFR_OP_T3IV])
        2'h0:    timer3Interval <= `OFR_T3IV_00;
        2'h1:    timer3Interval <= `OFR_T3IV_01;
        2'h2:    timer3Interval <= `OFR_T3IV_10;
        default: timer3Interval <= `OFR_T3IV_11;
      endcase
      case (option_r[`OFR_OP_WDT])
        2'h0:    watchdogPeriodMs <= `OFR_WDT_00;
        2'h1:    watchdogPeriodMs <= `OFR_WDT_01;
        2'h2:    watchdogPeriodMs <= `OFR_WDT_10;
        default: watchdogPeriodMs <= `OFR_WDT_11;
      endcase
      case (option_r[`OFR_OP_ADCK])
        2'h0:    adcClkDiv <= `OFR_ADCK_00;
        2'h1:    adcClkDiv <= `OFR_ADCK_01;
        2'h2:    adcClkDiv <= `OFR_ADCK_10;
        default: adcClkDiv <= `OFR_ADCK_11;
      endcase
      port1WakeBits <= wake_r;
      p10Drive <= t2Tog_r & pinSel_r[`OFR_PS_T2OE];
      p10Oe <= pinSel_r[`OFR_PS_T2OE];
      p35Drive <= t1Tog_r & pinSel_r[`OFR_PS_T1OE];
      p35Oe <= pinSel_r[`OFR_PS_T1OE];
      p34Drive <= t0Tog_r & pinSel_r[`OFR_PS_T0OE];
      p34Oe <= pinSel_r[`OFR_PS_T0OE];
      conversionDoneFlag <= flags_r[`OFR_FL_ADC];
      extIrq2EdgeFlag <= flags_r[`OFR_FL_EXT2];
      pinChangeFlag <= flags_r[`OFR_FL_PCHG];
      thirdTimerFlag <= flags_r[`OFR_FL_T3];
      // level interrupt from enabled sticky status
      irqOut <= |(evStat_r & irqEn_r);
    end
  end

endmodule // ofr_option_regs
`default_nettype wire

// [dv/ofr_option_regs_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker for the option register bank
module ofr_option_regs_chk (
  // clock, reset, bus
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // events and pins
  input wire logic adcDone,
  input wire logic adcStart,
  input wire logic timer3Tick,
  input wire logic timer3Ack,
  input wire logic ext2Pin,
  // watched outputs
  input wire logic uartTxOnP31,
  input wire logic uartTxOnP16,
  input wire logic p10Drive,
  input wire logic p10Oe,
  input wire logic conversionDoneFlag,
  input wire logic extIrq2EdgeFlag,
  input wire logic thirdTimerFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // access waiting, then a one-cycle answer
  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence answer;
    pready ##1 !pready;
  endsequence
  AST_APB_ANSWER: assert property (accessWait |=> answer)
    else $error("pready late or held");
  AST_ROUTE_ONEHOT: assert property (uartTxOnP31 != uartTxOnP16)
    else $error("uart route not one-hot");
  AST_P10_QUIET: assert property (!p10Oe |-> !p10Drive)
    else $error("p10 driven while off");
  AST_ADC_SET: assert property (adcDone |-> ##2 conversionDoneFlag)
    else $error("adc flag not set");
  AST_ADC_START: assert property (adcStart && !adcDone |-> ##2 !conversionDoneFlag)
    else $error("adc flag kept after start");
  AST_EXT2_FALL: assert property ($fell(ext2Pin) |-> ##[2:5] extIrq2EdgeFlag)
    else $error("ext2 fall missed");
  AST_T3_SET: assert property (timer3Tick |-> ##2 thirdTimerFlag)
    else $error("t3 flag not set");
  AST_T3_WINS: assert property (timer3Tick && timer3Ack |-> ##2 thirdTimerFlag)
    else $error("t3 ack beat a same-cycle tick");
  AST_T3_ACK: assert property (timer3Ack && !timer3Tick |-> ##2 !thirdTimerFlag)
    else $error("t3 flag kept after ack");
endmodule // ofr_option_regs_chk
bind ofr_option_regs ofr_option_regs_chk chk (.*);
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench for the option register bank
module tb;
  // byte address is four times the index
  localparam logic [11:0] PS = 12'h93 * 4, OP = 12'h94 * 4, FL = 12'h95 * 4,
    WK = 12'h96 * 4, IE = 12'h97 * 4, EC = 12'h98 * 4, ES = 12'h99 * 4;
  logic        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic        ext2Pin = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [8:0]  ev = 0;
  logic [7:0]  port1Pins = 0;
  int          fails = 0, checks = 0;
  wire adcDone, adcStart, timer3Tick, timer0Ovf, timer1Ovf, timer2Ovf;
  wire ext2Ack, pinChgAck, timer3Ack, pready, pslverr, uartTxOnP31, uartTxOnP16;
  wire uartSinglePin, timer3FastClk, p10Drive, p10Oe, p35Drive, p35Oe, p34Drive, p34Oe;
  wire conversionDoneFlag, extIrq2EdgeFlag, pinChangeFlag, thirdTimerFlag, irqOut;
  wire [31:0] prdata;
  wire [1:0]  pin21Mode, pin20Mode;
  wire [16:0] timer3Interval;
  wire [8:0]  watchdogPeriodMs;
  wire [5:0]  adcClkDiv;
  wire [7:0]  port1WakeBits;
  // one bit of ev per engine event
  assign {timer3Ack, pinChgAck, ext2Ack, timer2Ovf, timer1Ovf, timer0Ovf, timer3Tick,
          adcStart, adcDone} = ev;
  ofr_option_regs dut (.*);
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // ==========================================
  // tasks
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // one apb transfer, idle edge first so no signal is driven twice
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic rdc(string nm, logic [11:0] a, logic [31:0] exp);
    apb(0, a, 0);
    chk(nm, exp, rd);
  endtask
  // k one-cycle pulses, then let flags and decodes settle
  task automatic pulse(logic [8:0] m, int k);
    repeat (k) begin
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] v;
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    rdc("pinsel", PS, 32'h05);
    rdc("wake", WK, 0);
    rdc("flags", FL, 0);
    chk("p20 mode", 1, 32'(pin20Mode));
    $display("end reset");
    for (int k = 0; k < 4; k++) begin
      v = {k[0], k[0], k[1:0], k[1:0], k[1:0]};
      apb(1, OP, {24'h0, v});
      rdc("option", OP, {24'h0, v});
      chk("wdt", 400 >> k, 32'(watchdogPeriodMs));
      chk("adc div", 32 >> k, 32'(adcClkDiv));
      chk("t3 ivl", k == 3 ? 65536 : 32768 >> k, 32'(timer3Interval));
      chk("t3 clk", k % 2, 32'(timer3FastClk));
      chk("1wire", k % 2, 32'(uartSinglePin));
    end
    $display("end options");
    apb(1, PS, 32'hff);
    rdc("pinsel ff", PS, 32'hff);
    chk("p16", 1, 32'(uartTxOnP16));
    chk("p21 mode", 3, 32'(pin21Mode));
    pulse(9'h020, 1);
    chk("p10", 1, 32'(p10Drive));
    pulse(9'h010, 1);
    chk("p35", 1, 32'(p35Drive));
    pulse(9'h008, 31);
    chk("p34 31", 0, 32'(p34Drive));
    pulse(9'h008, 1);
    chk("p34 32", 1, 32'(p34Drive));
    apb(1, PS, 0);
    pulse(0, 1);
    chk("p31", 1, 32'(uartTxOnP31));
    chk("p35 oe", 0, 32'(p35Oe));
    chk("p34 oe", 0, 32'(p34Oe));
    $display("end pins");
    apb(1, WK, 1);
    pulse(0, 1);
    chk("wake", 1, 32'(port1WakeBits));
    pulse(9'h005, 1);
    ext2Pin <= 0;
    port1Pins <= 8'h03;
    pulse(0, 1);
    rdc("all set", FL, 32'h17);
    chk("pchg pin", 1, 32'(pinChangeFlag));
    apb(1, FL, 32'hfb);
    rdc("fb", FL, 32'h13);
    apb(1, FL, 32'hef);
    rdc("ef", FL, 32'h03);
    pulse(9'h080, 1);
    rdc("pchg ack", FL, 32'h01);
    port1Pins <= 8'h01;
    pulse(9'h100, 1);
    rdc("off pin", FL, 0);
    port1Pins <= 8'h00;
    pulse(9'h104, 1);
    rdc("set wins", FL, 32'h03);
    apb(1, FL, 32'hfd);
    apb(1, FL, 32'hfe);
    rdc("fd fe", FL, 0);
    pulse(9'h001, 1);
    pulse(9'h002, 1);
    ext2Pin <= 1;
    pulse(0, 1);
    ext2Pin <= 0;
    pulse(0, 1);
    pulse(9'h040, 1);
    rdc("start ack", FL, 0);
    $display("end flags");
    apb(1, EC, 32'hf);
    apb(1, IE, 1);
    pulse(9'h004, 1);
    chk("irq", 1, 32'(irqOut));
    apb(1, IE, 0);
    pulse(0, 1);
    chk("masked", 0, 32'(irqOut));
    rdc("evstat", ES, 1);
    apb(1, IE, 1);
    apb(1, EC, 1);
    rdc("evclr", EC, 0);
    chk("cleared", 0, 32'(irqOut));
    rdc("unmapped", 12'h000, 0);
    chk("slverr", 1, 32'(er));
    $display("end irq");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
